// *** rtl/asw_defs.vh ***
`ifndef ASW_DEFS_VH
`define ASW_DEFS_VH
// ---------------------------------------------------------------
// Host register map (word index on the command port)
// ---------------------------------------------------------------
`define ASW_REG_CTRL 4'h0
`define ASW_REG_STAT 4'h1
`define ASW_REG_ROM_LO 4'h2
`define ASW_REG_ROM_HI 4'h3
`define ASW_REG_WDATA 4'h4
`define ASW_REG_RDATA 4'h5
// CTRL fields: write starts an operation
`define ASW_CTRL_GO 0
`define ASW_CTRL_OP_LSB 1
`define ASW_CTRL_OP_MSB 3
`define ASW_CTRL_FAST 4
// Operations
`define ASW_OP_RESET 3'h0
`define ASW_OP_WRITE_BYTE 3'h1
`define ASW_OP_READ_BYTE 3'h2
`define ASW_OP_BIT 3'h3
// STAT fields
`define ASW_STAT_BUSY 0
`define ASW_STAT_PRESENCE 1
`define ASW_STAT_FAST 2
`define ASW_STAT_CRC_OK 3
`define ASW_STAT_STS_OK 4
`define ASW_STAT_ROM_DONE 5
// Bus commands
`define ASW_CMD_MATCH 8'h55
`define ASW_CMD_SKIP 8'hCC
`define ASW_CMD_OD_SKIP 8'h3C
`define ASW_CMD_OD_MATCH 8'h69
`define ASW_CMD_STATUS_READ 8'hF5
`define ASW_CMD_LATCH_WRITE 8'h5A
`define ASW_CONFIRM 8'hAA
`define ASW_CMD_READ_ROM 8'h33
`define ASW_CMD_SEARCH 8'hF0
`define ASW_CMD_RESUME 8'hA5
// Slot timing in ns
`define ASW_CLK_NS 5
`define ASW_STD_RSTL_NS 640000
`define ASW_STD_PDS_NS 70000
`define ASW_STD_RSTH_NS 600000
`define ASW_STD_SLOT_NS 70000
`define ASW_STD_LOW1_NS 6000
`define ASW_STD_SMP_NS 12000
`define ASW_STD_REC_NS 5000
`define ASW_OD_RSTL_NS 70000
`define ASW_OD_PDS_NS 8500
`define ASW_OD_RSTH_NS 60000
`define ASW_OD_SLOT_NS 10000
`define ASW_OD_LOW1_NS 1000
`define ASW_OD_SMP_NS 1500
`define ASW_OD_REC_NS 2000
`endif

// *** rtl/asw_master.v ***
`timescale 1ns/1ps
`include "asw_defs.vh"
module asw_master #(
  parameter RSTL_STD = `ASW_STD_RSTL_NS / `ASW_CLK_NS,
  parameter RSTH_STD = `ASW_STD_RSTH_NS / `ASW_CLK_NS,
  parameter PDS_STD_CYC = `ASW_STD_PDS_NS / `ASW_CLK_NS,
  parameter SLOT_STD_CYC = `ASW_STD_SLOT_NS / `ASW_CLK_NS,
  parameter LOW1_STD_CYC = (`ASW_STD_LOW1_NS + `ASW_CLK_NS - 1)
    / `ASW_CLK_NS,
  parameter SMP_STD_CYC = `ASW_STD_SMP_NS / `ASW_CLK_NS,
  parameter REC_STD_CYC = (`ASW_STD_REC_NS + `ASW_CLK_NS - 1)
    / `ASW_CLK_NS,
  parameter RSTL_OD_CYC = (`ASW_OD_RSTL_NS + `ASW_CLK_NS - 1)
    / `ASW_CLK_NS,
  parameter PDS_OD_CYC = `ASW_OD_PDS_NS / `ASW_CLK_NS,
  parameter RSTH_OD_CYC = (`ASW_OD_RSTH_NS + `ASW_CLK_NS - 1)
    / `ASW_CLK_NS,
  parameter SLOT_OD_CYC = `ASW_OD_SLOT_NS / `ASW_CLK_NS,
  parameter LOW1_OD_CYC = (`ASW_OD_LOW1_NS + `ASW_CLK_NS - 1)
    / `ASW_CLK_NS,
  parameter SMP_OD_CYC = `ASW_OD_SMP_NS / `ASW_CLK_NS,
  parameter REC_OD_CYC = (`ASW_OD_REC_NS + `ASW_CLK_NS - 1)
    / `ASW_CLK_NS
) (
  input wire CLK_SYS,
  input wire RST_B,
  input wire [3:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  input wire BUS_IN,
  output reg BUS_OUT,
  output reg BUS_OE
);
  localparam TW = 18;
  // ---------------------------------------------------------------
  // Slot timing in clock cycles, cut to the timer width
  // ---------------------------------------------------------------
  localparam [TW-1:0] PDS_STD = PDS_STD_CYC[TW-1:0];
  localparam [TW-1:0] SLOT_STD = SLOT_STD_CYC[TW-1:0];
  localparam [TW-1:0] LOW1_STD = LOW1_STD_CYC[TW-1:0];
  localparam [TW-1:0] SMP_STD = SMP_STD_CYC[TW-1:0];
  localparam [TW-1:0] REC_STD = REC_STD_CYC[TW-1:0];
  localparam [TW-1:0] RSTL_OD = RSTL_OD_CYC[TW-1:0];
  localparam [TW-1:0] PDS_OD = PDS_OD_CYC[TW-1:0];
  localparam [TW-1:0] RSTH_OD = RSTH_OD_CYC[TW-1:0];
  localparam [TW-1:0] SLOT_OD = SLOT_OD_CYC[TW-1:0];
  localparam [TW-1:0] LOW1_OD = LOW1_OD_CYC[TW-1:0];
  localparam [TW-1:0] SMP_OD = SMP_OD_CYC[TW-1:0];
  localparam [TW-1:0] REC_OD = REC_OD_CYC[TW-1:0];
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_RLOW = 8'h02;
  localparam [7:0] S_RPDS = 8'h04;
  localparam [7:0] S_RHI = 8'h08;
  localparam [7:0] S_SLOW = 8'h10;
  localparam [7:0] S_SSMP = 8'h20;
  localparam [7:0] S_SEND = 8'h40;
  localparam [7:0] S_SREC = 8'h80;
  reg [7:0] state_q;
  reg [2:0] op_q;
  reg [7:0] sh_q;
  reg [3:0] bit_q;
  reg [3:0] nbits_q;
  reg fast_speed_flag_q;
  reg fast_req_q;
  reg presence_q;
  reg rom_done_q;
  reg [7:0] rdata_q;
  reg [31:0] rom_lo_q;
  reg [31:0] rom_hi_q;
  reg bus_s1_q;
  reg bus_s2_q;
  reg tload;
  reg [TW-1:0] tcount;
  wire tdone;
  wire [7:0] crc_v;
  wire crc_ok;
  wire sts_ok;
  // ---------------------------------------------------------------
  // Bus input synchroniser
  // ---------------------------------------------------------------
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      bus_s1_q <= 1'b1;
      bus_s2_q <= 1'b1;
    end else begin
      bus_s1_q <= BUS_IN;
      bus_s2_q <= bus_s1_q;
    end
  end
  asw_timer #(.W(TW)) u_timer (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .load(tload),
    .count(tcount),
    .done(tdone)
  );
  // ---------------------------------------------------------------
  // Check byte over the stored id (64 bits leave zero if valid)
  // ---------------------------------------------------------------
  function [7:0] crc_step;
    input [7:0] c;
    input b;
    reg fb;
    begin
      fb = c[0] ^ b;
      crc_step = {fb, c[7:5], c[4] ^ fb, c[3] ^ fb, c[2:1]};
    end
  endfunction
  genvar gi;
  wire [7:0] crc_chain [0:64];
  assign crc_chain[0] = 8'h00;
  generate
    for (gi = 0; gi < 64; gi = gi + 1) begin : g_crc
      wire b = (gi < 32) ? rom_lo_q[gi % 32] : rom_hi_q[gi % 32];
      assign crc_chain[gi+1] = crc_step(crc_chain[gi], b);
    end
  endgenerate
  assign crc_v = crc_chain[64];
  assign crc_ok = (crc_v == 8'h00);
  // Status byte check: upper nibble is inverse of lower
  assign sts_ok = (rdata_q[7:4] == ~rdata_q[3:0]);
  wire is_rom_cmd = (sh_q == `ASW_CMD_MATCH) || (sh_q == `ASW_CMD_SKIP) ||
    (sh_q == `ASW_CMD_OD_SKIP) || (sh_q == `ASW_CMD_OD_MATCH) ||
    (sh_q == `ASW_CMD_READ_ROM) || (sh_q == `ASW_CMD_SEARCH) ||
    (sh_q == `ASW_CMD_RESUME);
  // ---------------------------------------------------------------
  // Command port
  // ---------------------------------------------------------------
  wire go = WR && (ADDR == `ASW_REG_CTRL) && WDATA[`ASW_CTRL_GO] &&
    (state_q == S_IDLE);
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rom_lo_q <= 32'h0000_0000;
      rom_hi_q <= 32'h0000_0000;
      fast_req_q <= 1'b0;
      RDATA <= 32'h0000_0000;
    end else begin
      if (WR && ADDR == `ASW_REG_ROM_LO) begin
        rom_lo_q <= WDATA;
      end
      if (WR && ADDR == `ASW_REG_ROM_HI) begin
        rom_hi_q <= WDATA;
      end
      if (go) begin
        fast_req_q <= WDATA[`ASW_CTRL_FAST];
      end
      if (RD) begin
        case (ADDR)
          `ASW_REG_STAT: RDATA <= {26'h0, rom_done_q, sts_ok, crc_ok,
            fast_speed_flag_q, presence_q, state_q != S_IDLE};
          `ASW_REG_ROM_LO: RDATA <= rom_lo_q;
          `ASW_REG_ROM_HI: RDATA <= rom_hi_q;
          `ASW_REG_RDATA: RDATA <= {24'h0, rdata_q};
          default: RDATA <= 32'h0000_0000;
        endcase
      end else begin
        RDATA <= 32'h0000_0000;
      end
    end
  end
  // ---------------------------------------------------------------
  // Slot engine
  // ---------------------------------------------------------------
  wire fast = fast_speed_flag_q;
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= S_IDLE;
      op_q <= `ASW_OP_RESET;
      sh_q <= 8'hFF;
      bit_q <= 4'h0;
      nbits_q <= 4'h8;
      fast_speed_flag_q <= 1'b0;
      presence_q <= 1'b0;
      rdata_q <= 8'h00;
      BUS_OUT <= 1'b0;
      BUS_OE <= 1'b0;
      tload <= 1'b0;
      tcount <= {TW{1'b0}};
    end else begin
      tload <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (go) begin
            op_q <= WDATA[`ASW_CTRL_OP_MSB:`ASW_CTRL_OP_LSB];
            sh_q <= WDATA[15:8];
            bit_q <= 4'h0;
            nbits_q <= (WDATA[`ASW_CTRL_OP_MSB:`ASW_CTRL_OP_LSB] ==
              `ASW_OP_BIT) ? 4'h1 : 4'h8;
            tload <= 1'b1;
            if (WDATA[`ASW_CTRL_OP_MSB:`ASW_CTRL_OP_LSB] ==
                `ASW_OP_RESET) begin
              // Reset pulse ends any looping command
              BUS_OE <= 1'b1;
              tcount <= fast ? RSTL_OD : RSTL_STD[TW-1:0];
              state_q <= S_RLOW;
            end else begin
              BUS_OE <= 1'b1;
              tcount <= fast ? LOW1_OD : LOW1_STD;
              state_q <= S_SLOW;
            end
          end
        end
        S_RLOW: if (tdone) begin
          BUS_OE <= 1'b0;
          presence_q <= 1'b0;
          tload <= 1'b1;
          tcount <= fast ? PDS_OD : PDS_STD;
          state_q <= S_RPDS;
        end
        S_RPDS: if (tdone) begin
          presence_q <= ~bus_s2_q;
          tload <= 1'b1;
          tcount <= fast ? RSTH_OD : RSTH_STD[TW-1:0];
          state_q <= S_RHI;
        end
        S_RHI: if (tdone) begin
          state_q <= S_IDLE;
        end
        S_SLOW: if (tdone) begin
          // Release for a one or a read slot, hold low for a zero
          if (op_q == `ASW_OP_READ_BYTE || sh_q[0]) begin
            BUS_OE <= 1'b0;
          end
          tload <= 1'b1;
          tcount <= (fast ? SMP_OD : SMP_STD) - (fast ? LOW1_OD : LOW1_STD);
          state_q <= S_SSMP;
        end
        S_SSMP: if (tdone) begin
          sh_q <= {bus_s2_q, sh_q[7:1]};
          tload <= 1'b1;
          tcount <= (fast ? SLOT_OD : SLOT_STD) - (fast ? SMP_OD : SMP_STD);
          state_q <= S_SEND;
        end
        S_SEND: if (tdone) begin
          BUS_OE <= 1'b0;
          tload <= 1'b1;
          tcount <= fast ? REC_OD : REC_STD;
          bit_q <= bit_q + 4'h1;
          state_q <= S_SREC;
        end
        S_SREC: if (tdone) begin
          if (bit_q == nbits_q) begin
            rdata_q <= (nbits_q == 4'h1) ? {7'h0, sh_q[7]} : sh_q;
            // Overdrive ROM byte sent at standard speed
            if (op_q == `ASW_OP_WRITE_BYTE && !fast && fast_req_q &&
                (sh_q == `ASW_CMD_OD_SKIP || sh_q == `ASW_CMD_OD_MATCH))
              fast_speed_flag_q <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            BUS_OE <= 1'b1;
            tload <= 1'b1;
            tcount <= fast ? LOW1_OD : LOW1_STD;
            state_q <= S_SLOW;
          end
        end
        default: state_q <= S_IDLE;
      endcase
      if (state_q == S_RHI && tdone && !presence_q)
        fast_speed_flag_q <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // ROM stage tracker: a ROM command byte sent since the last reset
  // ---------------------------------------------------------------
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rom_done_q <= 1'b0;
    end else if (state_q == S_RHI && tdone) begin
      rom_done_q <= 1'b0;
    end else if (state_q == S_SREC && tdone && bit_q == nbits_q &&
        op_q == `ASW_OP_WRITE_BYTE && is_rom_cmd) begin
      rom_done_q <= 1'b1;
    end
  end
endmodule

// *** rtl/asw_timer.v ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Down counter: loads a count, pulses done when it expires
// ---------------------------------------------------------------
module asw_timer #(
  parameter W = 18
) (
  input wire clk,
  input wire rst_b,
  input wire load,
  input wire [W-1:0] count,
  output reg done
);
  reg [W-1:0] cnt_q;
  reg run_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      cnt_q <= count;
      run_q <= 1'b1;
      done <= 1'b0;
    end else if (run_q) begin
      if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
        run_q <= 1'b0;
        done <= 1'b1;
      end else begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        done <= 1'b0;
      end
    end else begin
      done <= 1'b0;
    end
  end
endmodule

// *** testbench/asw_dev_model.sv ***
`timescale 1ns/1ps
// ----------------------------
// Switch device on the line
// ----------------------------
module asw_dev_model #(
  parameter STD_SMP_NS = 30000,
  parameter STD_RST_NS = 80000,
  parameter STD_PDH_NS = 15000,
  parameter STD_PDL_NS = 60000,
  parameter OD_SMP_NS = 4000,
  parameter OD_RST_NS = 40000,
  parameter OD_PDH_NS = 2000,
  parameter OD_PDL_NS = 8000
) (
  input wire bus_oe,
  output wire line
);
  reg pull = 1'b0;
  reg fast_speed_flag = 1'b0;
  reg [1:0] latch = 2'b11;
  reg [1:0] st = 2'h0;
  reg [2:0] n = 3'h0;
  reg [7:0] sh = 8'h0;
  reg [7:0] tx = 8'hFF;
  reg [7:0] smp = 8'h0;
  real t0;
  wire [3:0] nib = {latch[1], latch[1], latch[0], latch[0]};
  assign line = !(bus_oe | pull);
  always @(negedge line) if (!pull) begin
    t0 = $realtime;
    pull = (st == 2'h2) && !tx[n];
    #(fast_speed_flag ? OD_SMP_NS : STD_SMP_NS);
    sh = {line, sh[7:1]};
    if (n == 3'h7) smp = {~nib, nib};
    pull = 1'b0;
    wait (line);
    if ($realtime - t0 > (fast_speed_flag ? OD_RST_NS : STD_RST_NS)) begin
      #(fast_speed_flag ? OD_PDH_NS : STD_PDH_NS);
      pull = 1'b1;
      #(fast_speed_flag ? OD_PDL_NS : STD_PDL_NS);
      pull = 1'b0;
      st = 2'h0;
      n = 3'h0;
    end else begin
      n = n + 3'h1;
      if (n == 3'h0) begin
        if (st == 2'h0 && sh == 8'h3C) fast_speed_flag = 1'b1;
        if (st == 2'h0) st = (sh == 8'hCC || sh == 8'h3C) ? 2'h1 : 2'h3;
        else if (st == 2'h2 || (st == 2'h1 && sh == 8'hF5)) st = 2'h2;
        tx = smp;
      end
    end
  end
endmodule

// *** testbench/asw_master_tb_top.sv ***
`timescale 1ns/1ps
`include "asw_defs.vh"
// ----------------------------
// Bench top
// ----------------------------
module asw_master_tb_top;
  reg CLK_SYS = 1'b0;
  reg RST_B = 1'b0;
  reg [3:0] ADDR = 4'h0;
  reg [31:0] WDATA = 32'h0;
  reg WR = 1'b0;
  reg RD = 1'b0;
  wire [31:0] RDATA;
  wire BUS_OUT;
  wire BUS_OE;
  wire line;
  integer n_mismatch = 0;
  integer checks_done = 0;
  integer k;
  reg [31:0] d;
  always #2.5 CLK_SYS = ~CLK_SYS;
  asw_master #(.RSTL_STD(1000), .RSTH_STD(1000), .PDS_STD_CYC(300),
    .SLOT_STD_CYC(200), .LOW1_STD_CYC(20), .SMP_STD_CYC(60),
    .REC_STD_CYC(20), .RSTL_OD_CYC(700), .PDS_OD_CYC(150),
    .RSTH_OD_CYC(500), .SLOT_OD_CYC(100), .LOW1_OD_CYC(10),
    .SMP_OD_CYC(30), .REC_OD_CYC(10)) i_asw_master (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .BUS_IN(line), .BUS_OUT(BUS_OUT),
    .BUS_OE(BUS_OE));
  asw_dev_model #(.STD_SMP_NS(600), .STD_RST_NS(3000), .STD_PDH_NS(500),
    .STD_PDL_NS(2000), .OD_SMP_NS(300), .OD_RST_NS(1000), .OD_PDH_NS(200),
    .OD_PDL_NS(1000)) i_asw_dev_model (.bus_oe(BUS_OE), .line(line));
  task results;
    begin
      if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge CLK_SYS);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK_SYS);
      RD <= 1'b0;
      #1 d = RDATA;
    end
  endtask
  task wr(input [3:0] a, input [31:0] v);
    begin
      @(posedge CLK_SYS);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK_SYS);
      WR <= 1'b0;
    end
  endtask
  function [7:0] crc_of(input [55:0] v);
    integer j;
    reg [7:0] c;
    begin
      c = 8'h00;
      for (j = 0; j < 56; j = j + 1) begin
        c = (c[0] ^ v[j]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
      end
      crc_of = c;
    end
  endfunction
  task op(input [2:0] code, input [7:0] b, input f);
    integer i;
    begin
      @(posedge CLK_SYS);
      ADDR <= `ASW_REG_CTRL;
      WDATA <= {16'h0, b, 3'h0, f, code, 1'b1};
      WR <= 1'b1;
      @(posedge CLK_SYS);
      WR <= 1'b0;
      d = 32'h1;
      for (i = 0; i < 10000 && d[`ASW_STAT_BUSY]; i = i + 1) rd(`ASW_REG_STAT);
      if (d[`ASW_STAT_BUSY] !== 1'b0) begin
        chk("busy end", 32'h0, 32'h1);
        results;
      end
    end
  endtask
  task t_idle;
    begin
      rd(`ASW_REG_STAT);
      chk("fast", 32'h0, {31'h0, d[`ASW_STAT_FAST]});
      rd(4'hF);
      chk("unmapped", 32'h0, d);
      chk("latches", 32'h3, {30'h0, i_asw_dev_model.latch});
    end
  endtask
  task t_init;
    begin
      op(`ASW_OP_RESET, 8'h00, 1'b0);
      chk("presence", 32'h1, {31'h0, d[`ASW_STAT_PRESENCE]});
      op(`ASW_OP_WRITE_BYTE, `ASW_CMD_OD_SKIP, 1'b1);
      chk("host fast", 32'h1, {31'h0, d[`ASW_STAT_FAST]});
      chk("dev fast", 32'h1, {31'h0, i_asw_dev_model.fast_speed_flag});
      chk("rom done", 32'h1, {31'h0, d[`ASW_STAT_ROM_DONE]});
    end
  endtask
  task t_rom;
    reg [63:0] id;
    begin
      // Arbitrary family code and serial number
      id[55:0] = {48'h0123_4567_89AB, 8'h5E};
      id[63:56] = crc_of(id[55:0]);
      wr(`ASW_REG_ROM_LO, id[31:0]);
      wr(`ASW_REG_ROM_HI, id[63:32]);
      rd(`ASW_REG_ROM_HI);
      chk("id high", id[63:32], d);
      rd(`ASW_REG_STAT);
      chk("id check", 32'h1, {31'h0, d[`ASW_STAT_CRC_OK]});
      wr(`ASW_REG_ROM_HI, id[63:32] ^ 32'h0000_0100);
      rd(`ASW_REG_STAT);
      chk("id error", 32'h0, {31'h0, d[`ASW_STAT_CRC_OK]});
    end
  endtask
  task t_loop;
    begin
      op(`ASW_OP_WRITE_BYTE, `ASW_CMD_STATUS_READ, 1'b0);
      for (k = 0; k < 2; k = k + 1) begin
        op(`ASW_OP_READ_BYTE, 8'hFF, 1'b0);
        chk("status ok", 32'h1, {31'h0, d[`ASW_STAT_STS_OK]});
        rd(`ASW_REG_RDATA);
        chk("status", {24'h0, ~4'hF, 4'hF}, {24'h0, d[7:0]});
      end
    end
  endtask
  task t_abort;
    begin
      op(`ASW_OP_RESET, 8'h00, 1'b0);
      chk("presence", 32'h1, {31'h0, d[`ASW_STAT_PRESENCE]});
      chk("dev state", 32'h0, {30'h0, i_asw_dev_model.st});
      chk("rom clear", 32'h0, {31'h0, d[`ASW_STAT_ROM_DONE]});
    end
  endtask
  initial begin
    repeat (2) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    t_idle;
    t_rom;
    t_init;
    t_loop;
    t_abort;
    results;
  end
endmodule

// *** testbench/asw_monitor.sv ***
`timescale 1ns/1ps
// ----------------------------
// Port checker of the host
// ----------------------------
module asw_monitor #(
  parameter RSTL_STD = 128000,
  parameter RSTL_OD = 14000,
  parameter LOW1_STD = 1200,
  parameter LOW1_OD = 200,
  parameter REC_STD = 1000,
  parameter REC_OD = 400,
  parameter SLOT_STD = 14000,
  parameter SLOT_OD = 2000
) (
  input wire CLK_SYS,
  input wire RST_B,
  input wire [3:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [31:0] RDATA,
  input wire BUS_IN,
  input wire BUS_OUT,
  input wire BUS_OE
);
  localparam MIN_LOW = (LOW1_STD < LOW1_OD) ? LOW1_STD : LOW1_OD;
  localparam MIN_REC = (REC_STD < REC_OD) ? REC_STD : REC_OD;
  localparam MAX_RST = (RSTL_STD > RSTL_OD) ? RSTL_STD : RSTL_OD;
  localparam MAX_SLOT = (SLOT_STD > SLOT_OD) ? SLOT_STD : SLOT_OD;
  localparam MAX_LOW = ((MAX_RST > MAX_SLOT) ? MAX_RST : MAX_SLOT) + 16;
  reg [19:0] lo_q;
  reg [19:0] hi_q;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      lo_q <= 20'h0;
      hi_q <= 20'hFFFFF;
    end else begin
      lo_q <= BUS_OE ? lo_q + 20'h1 : 20'h0;
      hi_q <= BUS_OE ? 20'h0 : (&hi_q ? hi_q : hi_q + 20'h1);
    end
  end
  sequence stat_rd;
    RD && ADDR == 4'h1;
  endsequence
  out_low_a: assert property (BUS_OUT == 1'b0)
    else $error("bus data output not low");
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside read cycle");
  unmapped_read_a: assert property (RD && ADDR > 4'h5 |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  oe_reset_idle_a: assert property ($rose(RST_B) |-> !BUS_OE)
    else $error("line driven at reset release");
  low_min_a: assert property ($fell(BUS_OE) |-> lo_q >= MIN_LOW)
    else $error("line low pulse too short");
  low_max_a: assert property (lo_q <= MAX_LOW)
    else $error("line low pulse too long");
  recovery_a: assert property ($rose(BUS_OE) |-> hi_q >= MIN_REC)
    else $error("recovery gap too short");
  busy_drive_a: assert property (stat_rd ##0 BUS_OE |=> RDATA[0])
    else $error("not busy while driving line");
endmodule
bind asw_master asw_monitor #(.RSTL_STD(RSTL_STD), .RSTL_OD(RSTL_OD_CYC),
  .LOW1_STD(LOW1_STD_CYC), .LOW1_OD(LOW1_OD_CYC), .REC_STD(REC_STD_CYC),
  .REC_OD(REC_OD_CYC), .SLOT_STD(SLOT_STD_CYC), .SLOT_OD(SLOT_OD_CYC))
  i_asw_monitor (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .BUS_IN(BUS_IN), .BUS_OUT(BUS_OUT),
  .BUS_OE(BUS_OE));
